// File: pts_regs.svh
// pts_regs.svh: register offsets, field positions, reset values and timing
// assumes: included once by the core module and by the bench
`ifndef PTS_REGS_SVH
`define PTS_REGS_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define PTS_GPS_NS 16'h0200
`define PTS_GPS_SEC 16'h0204
`define PTS_CAB_NS 16'h0210
`define PTS_CAB_SEC 16'h0214
`define PTS_MASTER_SEC 16'h0220
`define PTS_TC_NS 16'h0230
`define PTS_TC_SEC 16'h0234
`define PTS_ERR_CLR 16'h0400
`define PTS_OUT_LINK 16'h0410
`define PTS_IN_LINK 16'h0420
`define PTS_TICK_HI 16'h1000
`define PTS_TICK_LO 16'h1008
`define PTS_TICK_CTRL 16'h1010
`define PTS_EP_SEC 16'h1100
`define PTS_EP_NS 16'h1108
`define PTS_EP_CTRL 16'h1110
`define PTS_EP_STEP 16'h1114
`define PTS_TRIM 16'h1120
`define PTS_SRC_SEL 16'h1150
`define PTS_VEC_BASE 16'h1800
`define PTS_VEC_END 16'h1880

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PTS_RUN_BIT 0
`define PTS_CLR_BIT 1
`define PTS_MASTER_BIT 2
`define PTS_EXT_BIT 8
`define PTS_LINK_UP_BIT 8
`define PTS_SRC_MAX 4'hB
`define PTS_SRC_NONE 4'hF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PTS_CLK_HZ 50000000
`define PTS_REF_HZ 10000000
`define PTS_TICK_NS 100
`define PTS_STEP_NS 400
`define PTS_NS_PER_SEC 1000000000

`endif

// File: pts_pkg.sv
// pts_pkg.sv: types shared by the posix time snapshot clock
// assumes: pts_regs.svh supplies all numbers
package pts_pkg;
	typedef logic [31:0] pts_word_t;
	typedef enum logic {
		PTS_REF_INTERNAL,
		PTS_REF_EXTERNAL
	} pts_ref_e;
endpackage : pts_pkg

// File: pts_clock.sv
// pts_clock.sv: tick counter, epoch clock, event captures, link status
// assumes: classic wishbone master on clk_i, event pins asynchronous except vector_irq_i, which is sampled directly
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`include "pts_regs.svh"
module pts_clock
	import pts_pkg::*;
#(
	parameter int NEXT = 12,
	parameter int NVEC = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// time events
	input wire logic gps_pps_i,
	input wire logic timecode_pps_i,
	input wire logic cable_time_rx_i,
	input wire logic [31:0] cable_rx_sec_i,
	input wire logic [NVEC-1:0] vector_irq_i,
	input wire logic [NEXT-1:0] ext_ref_i,
	// cable link
	input wire logic [7:0] out_link_err_i,
	input wire logic [7:0] in_link_err_i,
	input wire logic out_link_up_i,
	input wire logic in_link_up_i,
	output logic cable_tx_stb_o,
	output logic [31:0] cable_tx_sec_o
);

	localparam int NPIN = NEXT + 3;
	localparam logic [31:0] PHASE_INC = 32'((64'h1_0000_0000 * `PTS_REF_HZ) / `PTS_CLK_HZ);

	function automatic pts_word_t pts_merge(input pts_word_t old, input pts_word_t nw,
		input logic [3:0] sel);
		pts_word_t r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction : pts_merge

	logic [NPIN-1:0] pin_raw, s1, s2, s3, pin_lvl, pin_rise;
	logic [NEXT-1:0] ext_rise;
	logic wr, rd_req, step_wr, ns_wr, sec_wr, clr;
	logic tick_hi_wr, tick_lo_wr, tick_clr, tick_wr_any;
	logic [31:0] phase, eff_inc;
	logic [32:0] next_phase;
	logic int_tick, ext_tick, tick, tick_on, ext_sel_ok;
	pts_ref_e ref_kind;
	logic [31:0] sec, trim, step_reg, master_sent;
	logic [29:0] ns, next_ns;
	logic [31:0] snap_ns;
	logic signed [31:0] delta, ns_sum;
	logic sec_up, sec_down;
	logic [63:0] tick_cnt;
	logic tick_run, epoch_run, master_mode;
	logic [3:0] src_sel;
	logic [31:0] gps_ns, gps_sec, cab_ns, cab_sec, tc_ns, tc_sec;
	logic [31:0] vec_ns [NVEC];
	logic [31:0] vec_sec [NVEC];
	logic [7:0] out_err, in_err;
	logic [31:0] rd_data;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	assign rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	assign step_wr = wr && wb_adr_i == `PTS_EP_STEP;
	assign ns_wr = wr && wb_adr_i == `PTS_EP_NS;
	assign sec_wr = wr && wb_adr_i == `PTS_EP_SEC;
	assign clr = wr && wb_adr_i == `PTS_ERR_CLR;
	assign tick_hi_wr = wr && wb_adr_i == `PTS_TICK_HI;
	assign tick_lo_wr = wr && wb_adr_i == `PTS_TICK_LO;
	assign tick_clr = wr && wb_adr_i == `PTS_TICK_CTRL && wb_sel_i[0]
		&& wb_dat_i[`PTS_CLR_BIT];
	assign tick_wr_any = tick_hi_wr || tick_lo_wr || tick_clr;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= rd_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_req) begin
			wb_dat_o <= rd_data;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	assign pin_raw = {ext_ref_i, cable_time_rx_i, timecode_pps_i, gps_pps_i};
	assign ext_rise = pin_rise[NPIN-1:3];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			pin_lvl <= '0;
		end else begin
			s1 <= pin_raw;
			s2 <= s1;
			s3 <= s2;
			pin_lvl <= (s2 & s3) | (pin_lvl & (s2 | s3));
		end
	end

	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_rise
			// a rise counts when stages two and three are both high and the level is still low
			assign pin_rise[g] = s2[g] && s3[g] && !pin_lvl[g];
		end
	endgenerate

	// ----------------------------------------------------------------
	// 10 MHz master tick
	// ----------------------------------------------------------------
	assign eff_inc = PHASE_INC + {{16{trim[15]}}, trim[15:0]};
	assign next_phase = {1'b0, phase} + {1'b0, eff_inc};
	assign int_tick = next_phase[32];
	assign ext_sel_ok = src_sel <= `PTS_SRC_MAX;
	assign ext_tick = ext_sel_ok && ext_rise[src_sel];
	assign tick = ext_sel_ok ? ext_tick : int_tick;
	assign tick_on = tick && epoch_run;
	assign ref_kind = ext_sel_ok ? PTS_REF_EXTERNAL : PTS_REF_INTERNAL;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phase <= 32'h0000_0000;
		end else begin
			phase <= next_phase[31:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trim <= 32'h0000_0000;
			step_reg <= 32'h0000_0000;
			src_sel <= `PTS_SRC_NONE;
			tick_run <= 1'b1;
			epoch_run <= 1'b1;
			master_mode <= 1'b0;
		end else begin
			if (wr && wb_adr_i == `PTS_TRIM) trim <= pts_merge(trim, wb_dat_i, wb_sel_i);
			if (step_wr) step_reg <= pts_merge(step_reg, wb_dat_i, wb_sel_i);
			if (wr && wb_adr_i == `PTS_SRC_SEL && wb_sel_i[0]) src_sel <= wb_dat_i[3:0];
			if (wr && wb_adr_i == `PTS_TICK_CTRL && wb_sel_i[0])
				tick_run <= wb_dat_i[`PTS_RUN_BIT];
			if (wr && wb_adr_i == `PTS_EP_CTRL && wb_sel_i[0]) begin
				epoch_run <= wb_dat_i[`PTS_RUN_BIT];
				master_mode <= wb_dat_i[`PTS_MASTER_BIT];
			end
		end
	end

	chk_src_none_internal:
	assert property (src_sel == `PTS_SRC_NONE |-> tick == int_tick)
		else $error("tick not internal with no source");

	cov_ext_tick: cover property (ext_sel_ok && ext_tick);

	// ----------------------------------------------------------------
	// tick counter
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt <= 64'h0000_0000_0000_0000;
		end else if (tick_clr) begin
			tick_cnt <= 64'h0000_0000_0000_0000;
		end else if (tick_hi_wr) begin
			tick_cnt[63:32] <= pts_merge(tick_cnt[63:32], wb_dat_i, wb_sel_i);
		end else if (tick_lo_wr) begin
			tick_cnt[31:0] <= pts_merge(tick_cnt[31:0], wb_dat_i, wb_sel_i);
		end else if (tick && tick_run) begin
			tick_cnt <= tick_cnt + 64'h0000_0000_0000_0001;
		end
	end

	chk_tick_count:
	assert property (tick && tick_run && !tick_wr_any |=> tick_cnt == $past(tick_cnt) + 64'h1)
		else $error("tick counter did not advance");

	chk_tick_clear:
	assert property (tick_clr |=> tick_cnt == 64'h0)
		else $error("tick counter not cleared");

	// ----------------------------------------------------------------
	// epoch clock
	// ----------------------------------------------------------------
	always_comb begin
		delta = 32'sd0;
		if (tick_on) delta = `PTS_TICK_NS;
		if (step_wr) delta = delta + $signed(wb_dat_i[15:0]) * `PTS_STEP_NS;
		ns_sum = $signed({2'b00, ns}) + delta;
		sec_up = ns_sum >= `PTS_NS_PER_SEC;
		sec_down = ns_sum < 0;
		if (sec_up) begin
			next_ns = 30'(ns_sum - `PTS_NS_PER_SEC);
		end else if (sec_down) begin
			next_ns = 30'(ns_sum + `PTS_NS_PER_SEC);
		end else begin
			next_ns = ns_sum[29:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ns <= 30'h0000_0000;
		end else if (ns_wr) begin
			// values of a second or more are refused
			if (pts_merge({2'b00, ns}, wb_dat_i, wb_sel_i) < `PTS_NS_PER_SEC)
				ns <= 30'(pts_merge({2'b00, ns}, wb_dat_i, wb_sel_i));
		end else begin
			ns <= next_ns;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sec <= 32'h0000_0000;
		end else if (sec_wr) begin
			sec <= pts_merge(sec, wb_dat_i, wb_sel_i);
		end else if (sec_up && !ns_wr) begin
			sec <= sec + 32'h0000_0001;
		end else if (sec_down && !ns_wr) begin
			sec <= sec - 32'h0000_0001;
		end
	end

	assign snap_ns = {sec[1:0], ns};

	chk_ns_range:
	assert property (ns < `PTS_NS_PER_SEC)
		else $error("nanoseconds out of range");

	chk_sec_carry:
	assert property (sec_up && !sec_wr && !ns_wr && !step_wr
		|=> sec == $past(sec) + 32'h1 && ns < 30'd1000)
		else $error("seconds carry missing");

	chk_step_add:
	assert property (step_wr && !tick_on && wb_dat_i[15:0] == 16'h0001
		&& ns < 30'd999999000 |=> ns == $past(ns) + 30'd400)
		else $error("step did not add 400 ns");

	cov_step: cover property (step_wr && sec_down);

	// ----------------------------------------------------------------
	// cable master time
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cable_tx_stb_o <= 1'b0;
			cable_tx_sec_o <= 32'h0000_0000;
			master_sent <= 32'h0000_0000;
		end else begin
			cable_tx_stb_o <= 1'b0;
			if (master_mode && sec_up && !sec_wr && !ns_wr) begin
				cable_tx_stb_o <= 1'b1;
				cable_tx_sec_o <= sec + 32'h0000_0001;
				master_sent <= sec + 32'h0000_0001;
			end else if (!master_mode && pin_rise[2]) begin
				master_sent <= cable_rx_sec_i;
			end
		end
	end

	chk_master_send:
	assert property (master_mode && sec_up && !sec_wr && !ns_wr
		|=> cable_tx_stb_o && cable_tx_sec_o == $past(sec) + 32'h1 && master_sent == cable_tx_sec_o)
		else $error("master seconds not sent");

	cov_master: cover property (cable_tx_stb_o);

	// ----------------------------------------------------------------
	// event captures
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gps_ns <= 32'h0000_0000;
			gps_sec <= 32'h0000_0000;
			tc_ns <= 32'h0000_0000;
			tc_sec <= 32'h0000_0000;
			cab_ns <= 32'h0000_0000;
			cab_sec <= 32'h0000_0000;
		end else begin
			// captures change only on their own event
			if (pin_rise[0]) begin
				gps_ns <= snap_ns;
				gps_sec <= sec;
			end
			if (pin_rise[1]) begin
				tc_ns <= snap_ns;
				tc_sec <= sec;
			end
			if (pin_rise[2]) begin
				cab_ns <= snap_ns;
				cab_sec <= sec;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int v = 0; v < NVEC; v++) begin
				vec_ns[v] <= 32'h0000_0000;
				vec_sec[v] <= 32'h0000_0000;
			end
		end else begin
			for (int v = 0; v < NVEC; v++) begin
				if (vector_irq_i[v]) begin
					vec_ns[v] <= snap_ns;
					vec_sec[v] <= sec;
				end
			end
		end
	end

	chk_gps_capture:
	assert property (pin_rise[0] |=> gps_ns == $past(snap_ns) && gps_sec == $past(sec))
		else $error("gps capture wrong");

	chk_cable_capture:
	assert property (pin_rise[2] |=> cab_ns == $past(snap_ns) && cab_sec == $past(sec))
		else $error("cable capture wrong");

	chk_timecode_capture:
	assert property (pin_rise[1] |=> tc_ns == $past(snap_ns) && tc_sec == $past(sec))
		else $error("timecode capture wrong");

	chk_vector_ns:
	assert property (vector_irq_i[0] |=> vec_ns[0] == $past(snap_ns))
		else $error("vector ns capture wrong");

	chk_vector_sec:
	assert property (vector_irq_i[NVEC-1] |=> vec_sec[NVEC-1] == $past(sec))
		else $error("vector seconds capture wrong");

	chk_capture_hold:
	assert property (!pin_rise[0] |=> $stable(gps_ns) && $stable(gps_sec))
		else $error("gps capture changed without pulse");

	cov_gps: cover property (pin_rise[0] ##1 gps_ns == $past(snap_ns));

	// ----------------------------------------------------------------
	// link status and errors
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_err <= 8'h00;
			in_err <= 8'h00;
		end else begin
			// a new error in the clearing cycle survives
			out_err <= (clr ? 8'h00 : out_err) | out_link_err_i;
			in_err <= (clr ? 8'h00 : in_err) | in_link_err_i;
		end
	end

	chk_err_clear:
	assert property (clr && out_link_err_i == 8'h00 && in_link_err_i == 8'h00
		|=> out_err == 8'h00 && in_err == 8'h00)
		else $error("link errors not cleared");

	chk_err_sticky:
	assert property (in_link_err_i[0] |=> in_err[0] ##1 (in_err[0] || $past(clr)))
		else $error("inbound error not held");

	// ----------------------------------------------------------------
	// read decode
	// ----------------------------------------------------------------
	always_comb begin
		rd_data = 32'h0000_0000;
		if (wb_adr_i == `PTS_GPS_NS) begin
			rd_data = gps_ns;
		end else if (wb_adr_i == `PTS_GPS_SEC) begin
			rd_data = gps_sec;
		end else if (wb_adr_i == `PTS_CAB_NS) begin
			rd_data = cab_ns;
		end else if (wb_adr_i == `PTS_CAB_SEC) begin
			rd_data = cab_sec;
		end else if (wb_adr_i == `PTS_MASTER_SEC) begin
			rd_data = master_sent;
		end else if (wb_adr_i == `PTS_TC_NS) begin
			rd_data = tc_ns;
		end else if (wb_adr_i == `PTS_TC_SEC) begin
			rd_data = tc_sec;
		end else if (wb_adr_i == `PTS_OUT_LINK) begin
			rd_data = {23'h0, out_link_up_i, out_err};
		end else if (wb_adr_i == `PTS_IN_LINK) begin
			rd_data = {23'h0, in_link_up_i, in_err};
		end else if (wb_adr_i == `PTS_TICK_HI) begin
			rd_data = tick_cnt[63:32];
		end else if (wb_adr_i == `PTS_TICK_LO) begin
			rd_data = tick_cnt[31:0];
		end else if (wb_adr_i == `PTS_TICK_CTRL) begin
			rd_data = 32'h0000_0000;
			rd_data[`PTS_RUN_BIT] = tick_run;
			rd_data[`PTS_EXT_BIT] = ref_kind == PTS_REF_EXTERNAL;
		end else if (wb_adr_i == `PTS_EP_SEC) begin
			rd_data = sec;
		end else if (wb_adr_i == `PTS_EP_NS) begin
			rd_data = {2'b00, ns};
		end else if (wb_adr_i == `PTS_EP_CTRL) begin
			rd_data = 32'h0000_0000;
			rd_data[`PTS_RUN_BIT] = epoch_run;
			rd_data[`PTS_MASTER_BIT] = master_mode;
			rd_data[`PTS_EXT_BIT] = ref_kind == PTS_REF_EXTERNAL;
		end else if (wb_adr_i == `PTS_EP_STEP) begin
			rd_data = step_reg;
		end else if (wb_adr_i == `PTS_TRIM) begin
			rd_data = trim;
		end else if (wb_adr_i == `PTS_SRC_SEL) begin
			rd_data = {28'h0, src_sel};
		end else if (wb_adr_i >= `PTS_VEC_BASE && wb_adr_i < `PTS_VEC_END) begin
			rd_data = wb_adr_i[2] ? vec_sec[wb_adr_i[6:3]] : vec_ns[wb_adr_i[6:3]];
		end
	end

	chk_read_ack:
	assert property (rd_req && wb_adr_i == `PTS_EP_SEC && !sec_wr |=> wb_ack_o && wb_dat_o == $past(sec))
		else $error("seconds read wrong");

endmodule : pts_clock

// File: pts_time_src.sv
// pts_time_src.sv: model of the pulse sources, cable master and reference inputs
// assumes: the bench calls its tasks; outputs change by NBA after clk_i edges
`timescale 1ns/1ps
module pts_time_src (
	// clock
	input wire logic clk_i,
	// time sources
	output logic gps_pps_o,
	output logic timecode_pps_o,
	output logic cable_rx_o,
	output logic [31:0] cable_sec_o,
	output logic [11:0] ext_ref_o
);
	initial begin
		gps_pps_o = 1'b0;
		timecode_pps_o = 1'b0;
		cable_rx_o = 1'b0;
		cable_sec_o = 32'h00000000;
		ext_ref_o = 12'h000;
	end

	// kind 0 gps, 1 timecode, else cable receipt of sec
	task pulse(input int kind, input logic [31:0] sec);
		@(posedge clk_i);
		if (kind == 0) gps_pps_o <= 1'b1;
		else if (kind == 1) timecode_pps_o <= 1'b1;
		else begin
			cable_sec_o <= sec;
			cable_rx_o <= 1'b1;
		end
		repeat (3) @(posedge clk_i);
		gps_pps_o <= 1'b0;
		timecode_pps_o <= 1'b0;
		cable_rx_o <= 1'b0;
		@(posedge clk_i);
		// seconds no longer held: show garbage
		cable_sec_o <= ~sec;
		repeat (4) @(posedge clk_i);
	endtask : pulse

	// n edges on one reference input at 10 MHz
	task ext_ticks(input int idx, input int n);
		repeat (n) begin
			@(posedge clk_i);
			ext_ref_o[idx] <= 1'b1;
			repeat (2) @(posedge clk_i);
			ext_ref_o[idx] <= 1'b0;
			repeat (2) @(posedge clk_i);
		end
		repeat (5) @(posedge clk_i);
	endtask : ext_ticks
endmodule : pts_time_src

// File: tb.sv
// tb.sv: self-checking bench for pts_clock
// assumes: pts_time_src drives the time sources; assertions sit in the design
`timescale 1ns/1ps
`include "pts_regs.svh"
module tb;
	import pts_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [3:0] lanes = 4'hF;
	logic [15:0] wb_adr_i = 16'h0000;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [15:0] vector_irq_i = 16'h0000;
	logic [7:0] out_err = 8'h00;
	logic [7:0] in_err = 8'h00;
	logic out_up = 1'b0;
	logic in_up = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic tx_stb;
	logic [31:0] tx_sec;
	logic gps;
	logic tc;
	logic crx;
	logic [31:0] csec;
	logic [11:0] ext;
	pts_word_t rdata;
	int bad_count = 0;
	int comparisons = 0;

	pts_clock #(.NEXT(12), .NVEC(16)) u_dut (
		.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.gps_pps_i(gps), .timecode_pps_i(tc), .cable_time_rx_i(crx),
		.cable_rx_sec_i(csec), .vector_irq_i(vector_irq_i), .ext_ref_i(ext),
		.out_link_err_i(out_err), .in_link_err_i(in_err),
		.out_link_up_i(out_up), .in_link_up_i(in_up),
		.cable_tx_stb_o(tx_stb), .cable_tx_sec_o(tx_sec)
	);
	pts_time_src u_src (
		.clk_i(clk_i), .gps_pps_o(gps), .timecode_pps_o(tc),
		.cable_rx_o(crx), .cable_sec_o(csec), .ext_ref_o(ext)
	);

	initial forever #10 clk_i = ~clk_i;

	// ----------------------------------------------------------------
	// bus and compare helpers
	// ----------------------------------------------------------------
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : conclude

	task automatic same(input pts_word_t got, input pts_word_t exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : same

	task automatic bus(input logic w, input logic [15:0] a, input pts_word_t d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= lanes;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		rdata = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 16) begin
			bad_count++;
			conclude();
		end
	endtask : bus

	task automatic wr(input logic [15:0] a, input pts_word_t d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [15:0] a, input pts_word_t exp);
		bus(1'b0, a, 32'h00000000);
		same(rdata, exp);
	endtask : rd

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		rd(`PTS_SRC_SEL, 32'h0000000F);
		rd(`PTS_TICK_CTRL, 32'h00000001);
		rd(`PTS_EP_CTRL, 32'h00000001);
		rd(`PTS_ERR_CLR, 32'h00000000);
		rd(16'h0FFC, 32'h00000000);
		rd(`PTS_GPS_SEC, 32'h00000000);
		$display("test reset done");
	endtask : t_reset

	task automatic t_epoch;
		wr(`PTS_EP_CTRL, 32'h00000000);
		wr(`PTS_EP_SEC, 32'h00000005);
		wr(`PTS_EP_NS, 32'd999_999_900);
		wr(`PTS_EP_NS, 32'd1_000_000_000);
		rd(`PTS_EP_NS, 32'd999_999_900);
		wr(`PTS_EP_CTRL, 32'h00000001);
		repeat (20) @(posedge clk_i);
		rd(`PTS_EP_SEC, 32'h00000006);
		bus(1'b0, `PTS_EP_NS, 32'h00000000);
		same({31'h0, rdata >= 32'd100 && rdata < 32'd2000}, 32'h1);
		$display("test epoch done");
	endtask : t_epoch

	task automatic t_step;
		wr(`PTS_EP_CTRL, 32'h00000000);
		wr(`PTS_EP_SEC, 32'h00000007);
		wr(`PTS_EP_NS, 32'd1000);
		wr(`PTS_EP_STEP, 32'h00000003);
		rd(`PTS_EP_NS, 32'd2200);
		rd(`PTS_EP_STEP, 32'h00000003);
		wr(`PTS_EP_STEP, 32'h00000001);
		rd(`PTS_EP_NS, 32'd2600);
		wr(`PTS_EP_STEP, 32'h0000FFF9);
		rd(`PTS_EP_NS, 32'd999_999_800);
		rd(`PTS_EP_SEC, 32'h00000006);
		wr(`PTS_EP_STEP, 32'hABCD0001);
		rd(`PTS_EP_NS, 32'd200);
		rd(`PTS_EP_SEC, 32'h00000007);
		$display("test step done");
	endtask : t_step

	task automatic t_capture;
		wr(`PTS_EP_SEC, 32'h1234567B);
		wr(`PTS_EP_NS, 32'h2ABCDEF0);
		u_src.pulse(0, 32'h0);
		rd(`PTS_GPS_NS, 32'hEABCDEF0);
		rd(`PTS_GPS_SEC, 32'h1234567B);
		u_src.pulse(1, 32'h0);
		rd(`PTS_TC_NS, 32'hEABCDEF0);
		rd(`PTS_TC_SEC, 32'h1234567B);
		u_src.pulse(2, 32'h0000CAFE);
		rd(`PTS_CAB_NS, 32'hEABCDEF0);
		rd(`PTS_CAB_SEC, 32'h1234567B);
		rd(`PTS_MASTER_SEC, 32'h0000CAFE);
		wr(`PTS_EP_SEC, 32'h00000000);
		rd(`PTS_GPS_SEC, 32'h1234567B);
		rd(`PTS_CAB_NS, 32'hEABCDEF0);
		$display("test capture done");
	endtask : t_capture

	task automatic t_vector;
		logic [15:0] a;
		for (int n = 0; n < 16; n++) begin
			a = `PTS_VEC_BASE + 16'(8 * n);
			wr(`PTS_EP_NS, 32'(n * 1000 + 4));
			wr(`PTS_EP_SEC, 32'(n + 1));
			@(posedge clk_i);
			vector_irq_i <= 16'h0001 << n;
			@(posedge clk_i);
			vector_irq_i <= 16'h0000;
			rd(a, {2'(n + 1), 30'(n * 1000 + 4)});
			rd(a + 16'h0004, 32'(n + 1));
		end
		$display("test vector done");
	endtask : t_vector

	task automatic t_master;
		int n;
		wr(`PTS_EP_SEC, 32'h00000040);
		wr(`PTS_EP_NS, 32'd999_999_000);
		wr(`PTS_EP_CTRL, 32'h00000005);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (tx_stb !== 1'b1 && n < 300);
		if (n >= 300) begin
			bad_count++;
			conclude();
		end
		same(tx_sec, 32'h00000041);
		rd(`PTS_MASTER_SEC, 32'h00000041);
		rd(`PTS_EP_CTRL, 32'h00000005);
		$display("test master done");
	endtask : t_master

	task automatic t_link;
		@(posedge clk_i);
		out_err <= 8'h05;
		in_err <= 8'hA1;
		out_up <= 1'b1;
		in_up <= 1'b1;
		@(posedge clk_i);
		out_err <= 8'h00;
		in_err <= 8'h00;
		rd(`PTS_OUT_LINK, 32'h00000105);
		rd(`PTS_IN_LINK, 32'h000001A1);
		wr(`PTS_ERR_CLR, 32'h00000000);
		rd(`PTS_OUT_LINK, 32'h00000100);
		rd(`PTS_IN_LINK, 32'h00000100);
		$display("test link done");
	endtask : t_link

	task automatic t_source;
		wr(`PTS_SRC_SEL, 32'h00000003);
		rd(`PTS_SRC_SEL, 32'h00000003);
		rd(`PTS_TICK_CTRL, 32'h00000101);
		wr(`PTS_TICK_CTRL, 32'h00000003);
		rd(`PTS_TICK_LO, 32'h00000000);
		u_src.ext_ticks(3, 10);
		u_src.ext_ticks(2, 4);
		rd(`PTS_TICK_LO, 32'h0000000A);
		wr(`PTS_SRC_SEL, 32'h0000000C);
		rd(`PTS_TICK_CTRL, 32'h00000001);
		wr(`PTS_SRC_SEL, 32'h0000000F);
		$display("test source done");
	endtask : t_source

	task automatic t_tick;
		wr(`PTS_TICK_CTRL, 32'h00000000);
		wr(`PTS_TICK_HI, 32'h12345678);
		wr(`PTS_TICK_LO, 32'hFFFFFFFE);
		rd(`PTS_TICK_HI, 32'h12345678);
		rd(`PTS_TICK_LO, 32'hFFFFFFFE);
		wr(`PTS_TICK_CTRL, 32'h00000001);
		repeat (30) @(posedge clk_i);
		rd(`PTS_TICK_HI, 32'h12345679);
		wr(`PTS_TRIM, 32'h00001234);
		rd(`PTS_TRIM, 32'h00001234);
		lanes = 4'h2;
		wr(`PTS_TRIM, 32'h0000AB00);
		lanes = 4'hF;
		rd(`PTS_TRIM, 32'h0000AB34);
		wr(`PTS_TICK_CTRL, 32'h00000003);
		repeat (5000) @(posedge clk_i);
		bus(1'b0, `PTS_TICK_LO, 32'h00000000);
		same({31'h0, rdata >= 32'd995 && rdata <= 32'd1005}, 32'h1);
		$display("test tick done");
	endtask : t_tick

	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_epoch();
		t_step();
		t_capture();
		t_vector();
		t_master();
		t_link();
		t_source();
		t_tick();
		conclude();
	end
endmodule : tb
